// ### hw/phy_io_cfg_pkg.sv
// constants, types and register map of the pad, pin and dsp configuration bank
package phy_io_cfg_pkg;

    // clock rate
    localparam int CLK_MHZ = 50;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_PAD = 12'h302;
    localparam logic [11:0] IDX_SPARE = 12'h308;
    localparam logic [11:0] IDX_DAC_A = 12'h30b;
    localparam logic [11:0] IDX_DAC_B = 12'h30c;
    localparam logic [11:0] IDX_EQ = 12'h30f;
    localparam int ADDR_W = 14;
    localparam logic [13:0] BA_PAD = {IDX_PAD, 2'b00};
    localparam logic [13:0] BA_SPARE = {IDX_SPARE, 2'b00};
    localparam logic [13:0] BA_DAC_A = {IDX_DAC_A, 2'b00};
    localparam logic [13:0] BA_DAC_B = {IDX_DAC_B, 2'b00};
    localparam logic [13:0] BA_EQ = {IDX_EQ, 2'b00};

    // reset values
    localparam logic [15:0] RST_PAD = 16'h0000;
    localparam logic [15:0] RST_SPARE = 16'h0002;
    localparam logic [15:0] RST_DAC_A = 16'h0c00;
    localparam logic [15:0] RST_DAC_B = 16'h0020;
    localparam logic [15:0] RST_EQ = 16'h0464;

    // writable bits; all others read zero, except spare bits 1-0, which show the revision bit and the clock-off status
    localparam logic [15:0] WM_PAD = 16'hc047;
    localparam logic [15:0] WM_SPARE = 16'hfffc;
    localparam logic [15:0] WM_DAC_A = 16'h0fff;
    localparam logic [15:0] WM_DAC_B = 16'h003f;
    localparam logic [15:0] WM_EQ = 16'h07ff;

    // field positions
    localparam int TERM_LSB = 14;
    localparam int CLK25_OFF_BIT = 6;
    localparam int PIN2_LSB = 0;
    localparam int STATUS_BIT = 0;
    localparam int REV_BIT = 1;
    localparam int RXCLK_SEL_BIT = 2;
    localparam int FRZ_RXDIS_BIT = 4;
    localparam int MSE_BYP_BIT = 5;
    localparam int SETTLE_FRZ_BIT = 6;
    localparam int CNT_FRZ_EN_BIT = 7;
    localparam int CNT_FRZ_LONG_BIT = 8;
    localparam int WAIT_FRZ_LSB = 10;
    localparam int DAC_M1_LSB = 6;
    localparam int DAC_ZERO_LSB = 0;
    localparam int DAC_P1_LSB = 0;
    localparam int FFE1_TMR_LSB = 8;
    localparam int FFE1_HOLD_BIT = 7;

    // counter-timed freeze intervals
    localparam int FRZ_SHORT_US = 176;
    localparam int FRZ_LONG_US = 192;
    localparam int FRZ_SHORT_CYC = FRZ_SHORT_US * CLK_MHZ;
    localparam int FRZ_LONG_CYC = FRZ_LONG_US * CLK_MHZ;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        P2_CLK50 = 3'h0,
        P2_LED2 = 3'h1,
        P2_WAKE = 3'h2,
        P2_LOW3 = 3'h3,
        P2_MGMT_INTERRUPT_OUT = 3'h4,
        P2_LOW5 = 3'h5,
        P2_HIGH = 3'h6,
        P2_LOW7 = 3'h7
    } pin2_sel_t;

    typedef enum logic [1:0] {
        SYM_ZERO = 2'h0,
        SYM_PLUS = 2'h1,
        SYM_MINUS = 2'h2
    } mlt3_t;

    typedef enum logic {
        WR_IDLE = 1'b0,
        WR_RESP = 1'b1
    } wr_state_t;

    // adaptation state of the receiver, one-hot-ish flags
    typedef struct packed {
        logic receiver_disabled;
        logic low_power_idle_wake_state;
        logic low_power_idle_freeze_state;
        logic low_power_idle_wait_state;
        logic settled_adapt_state;
        logic lpi_refresh;
    } lpi_state_t;

    // wait_freeze order: [0] fagc .. [5] dc removal
    typedef struct packed {
        logic freeze_all;
        logic mse_bypass;
        logic settled_freeze_en;
        logic counter_freeze;
        logic [5:0] wait_freeze;
    } loop_freeze_t;

    typedef struct packed {
        logic clk50_output;
        logic second_led_out;
        logic wake_event_out;
        logic mgmt_interrupt_out;
    } pin2_src_t;

endpackage

// ### hw/low_power_idle_freeze_state_timer.sv
// counter-timed loop freeze started at each low-power-idle refresh
`timescale 1ns/1ps
module low_power_idle_freeze_state_timer #(
    parameter int SHORT_CYC = phy_io_cfg_pkg::FRZ_SHORT_CYC,
    parameter int LONG_CYC = phy_io_cfg_pkg::FRZ_LONG_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // control
    input wire logic enable,
    input wire logic long_sel,
    input wire logic refresh,
    // result
    output logic freeze
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic refresh_q;
    wire start = refresh & ~refresh_q & enable;
    wire [15:0] load_val = long_sel ? 16'(LONG_CYC) : 16'(SHORT_CYC);

    // RULE_07 timed freeze count
    assign cnt_d = start ? load_val : ((cnt_q != 16'h0000) ? cnt_q - 16'h0001 : cnt_q);
    assign freeze = (cnt_q != 16'h0000);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
            refresh_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            refresh_q <= refresh;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_timer_start;
        start |=> freeze [*8];
    endproperty
    a_timer_start: assert property (p_timer_start) else $error("freeze not held after start"); // RULE_07

    property p_timer_len;
        start |=> cnt_q == $past(load_val);
    endproperty
    a_timer_len: assert property (p_timer_len) else $error("freeze interval wrong"); // RULE_07
endmodule

// ### hw/phy_io_dsp_config_regs.sv
// pad, pin function, loop freeze, line driver and equalizer configuration bank
// Notes on behaviour
// RULE_01: termination field picks 50 or 25 ohm
// RULE_02: bit 6 clear drives 25 MHz clock
// RULE_03: pin2 select picks clock, leds, wake, interrupt, levels
// RULE_04: spare bit 1 fixed revision bit
// RULE_05: bit 2 rx clock select, bit 4 freeze
// RULE_06: bit 5 mse bypass, bit 6 settled freeze
// RULE_07: bit 7 timed freeze, bit 8 length
// RULE_08: bits 10-15 freeze loops in wait
// RULE_09: spare bit 0 shows clock-off status
// RULE_10: minus one code from bits 11-6
// RULE_11: zero code from bits 5-0
// RULE_12: plus one code from second register
// RULE_13: bits 10-8 set ffe stage1 timer
// RULE_14: bit 7 freezes ffe in stage1
// RULE_15: reserved bits read zero, writes ignored
`timescale 1ns/1ps
module phy_io_dsp_config_regs #(
    parameter int FRZ_SHORT_CYC = phy_io_cfg_pkg::FRZ_SHORT_CYC,
    parameter int FRZ_LONG_CYC = phy_io_cfg_pkg::FRZ_LONG_CYC,
    // arbitrary neutral value
    parameter logic REV_ID_BIT = 1'b0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // axi4-lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [phy_io_cfg_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [phy_io_cfg_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // pads
    output logic [1:0] mac_pad_termination_sel,
    input wire logic clk25_output,
    input wire logic [1:0] shared_pad_gpio_control,
    input wire logic shared_pin_i,
    output logic shared_pin_o,
    output logic shared_pin_oe,
    output logic led1_gpio_in,
    input wire logic master_mode,
    input wire phy_io_cfg_pkg::pin2_src_t pin2_src,
    output logic pin2_out,
    // adaptation loops
    input wire phy_io_cfg_pkg::lpi_state_t lpi_state,
    input wire logic ffe_stage1_active,
    output phy_io_cfg_pkg::loop_freeze_t loop_freeze,
    output logic rx_ref_clk_sel,
    output logic [2:0] ffe_stage1_timer,
    output logic ffe_stage1_freeze,
    output logic [6:0] dsp_aux_cfg,
    // line driver
    input wire phy_io_cfg_pkg::mlt3_t mlt3_symbol,
    output logic [5:0] ld_code
);
    logic [15:0] pad_q;
    logic [15:0] spare_q;
    logic [15:0] dac_a_q;
    logic [15:0] dac_b_q;
    logic [15:0] eq_q;
    logic aw_have_q;
    logic w_have_q;
    logic [phy_io_cfg_pkg::ADDR_W-1:0] awaddr_q;
    logic [15:0] wdata_q;
    logic [1:0] wstrb_q;
    phy_io_cfg_pkg::wr_state_t wr_state_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic pin_meta_q;
    logic pin_sync_q;
    logic [5:0] ld_code_q;
    // merge written byte lanes, keep only writable bits
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
                                          input logic [1:0] strb, input logic [15:0] mask);
        logic [15:0] m;
        m = {strb[1] ? val[15:8] : old[15:8], strb[0] ? val[7:0] : old[7:0]};
        return m & mask;
    endfunction
    // write side decode
    wire do_wr = aw_have_q & w_have_q & (wr_state_q == phy_io_cfg_pkg::WR_IDLE);
    wire ws_pad = (awaddr_q == phy_io_cfg_pkg::BA_PAD);
    wire ws_spare = (awaddr_q == phy_io_cfg_pkg::BA_SPARE);
    wire ws_dac_a = (awaddr_q == phy_io_cfg_pkg::BA_DAC_A);
    wire ws_dac_b = (awaddr_q == phy_io_cfg_pkg::BA_DAC_B);
    wire ws_eq = (awaddr_q == phy_io_cfg_pkg::BA_EQ);
    wire ws_hit = ws_pad | ws_spare | ws_dac_a | ws_dac_b | ws_eq;
    assign awready = ~aw_have_q;
    assign wready = ~w_have_q;
    assign bvalid = (wr_state_q == phy_io_cfg_pkg::WR_RESP);
    assign bresp = bresp_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'b00;
        end else begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= awaddr;
            end else if (do_wr) begin
                aw_have_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                wdata_q <= wdata[15:0];
                wstrb_q <= wstrb[1:0];
            end else if (do_wr) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state_q <= phy_io_cfg_pkg::WR_IDLE;
            bresp_q <= phy_io_cfg_pkg::RESP_OKAY;
        end else begin
            case (wr_state_q)
                phy_io_cfg_pkg::WR_IDLE: begin
                    if (do_wr) begin
                        wr_state_q <= phy_io_cfg_pkg::WR_RESP;
                        bresp_q <= ws_hit ? phy_io_cfg_pkg::RESP_OKAY
                                          : phy_io_cfg_pkg::RESP_SLVERR;
                    end
                end
                phy_io_cfg_pkg::WR_RESP: begin
                    if (bready) begin
                        wr_state_q <= phy_io_cfg_pkg::WR_IDLE;
                    end
                end
                default: begin
                    wr_state_q <= phy_io_cfg_pkg::WR_IDLE;
                end
            endcase
        end
    end
    // RULE_15 masked register writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pad_q <= phy_io_cfg_pkg::RST_PAD;
            spare_q <= phy_io_cfg_pkg::RST_SPARE & phy_io_cfg_pkg::WM_SPARE;
            dac_a_q <= phy_io_cfg_pkg::RST_DAC_A;
            dac_b_q <= phy_io_cfg_pkg::RST_DAC_B;
            eq_q <= phy_io_cfg_pkg::RST_EQ;
        end else if (do_wr) begin
            if (ws_pad) pad_q <= merge(pad_q, wdata_q, wstrb_q, phy_io_cfg_pkg::WM_PAD);
            if (ws_spare) spare_q <= merge(spare_q, wdata_q, wstrb_q, phy_io_cfg_pkg::WM_SPARE);
            if (ws_dac_a) dac_a_q <= merge(dac_a_q, wdata_q, wstrb_q, phy_io_cfg_pkg::WM_DAC_A);
            if (ws_dac_b) dac_b_q <= merge(dac_b_q, wdata_q, wstrb_q, phy_io_cfg_pkg::WM_DAC_B);
            if (ws_eq) eq_q <= merge(eq_q, wdata_q, wstrb_q, phy_io_cfg_pkg::WM_EQ);
        end
    end
    // field views
    wire clk25_out_disable = pad_q[phy_io_cfg_pkg::CLK25_OFF_BIT];
    wire [2:0] pin2_function_sel = pad_q[phy_io_cfg_pkg::PIN2_LSB +: 3];
    // RULE_04 fixed revision bit
    // RULE_09 clock-off status bit
    wire [15:0] spare_view = {spare_q[15:2], REV_ID_BIT, clk25_out_disable};
    // read side decode
    wire rs_pad = (araddr == phy_io_cfg_pkg::BA_PAD);
    wire rs_spare = (araddr == phy_io_cfg_pkg::BA_SPARE);
    wire rs_dac_a = (araddr == phy_io_cfg_pkg::BA_DAC_A);
    wire rs_dac_b = (araddr == phy_io_cfg_pkg::BA_DAC_B);
    wire rs_eq = (araddr == phy_io_cfg_pkg::BA_EQ);
    wire rs_hit = rs_pad | rs_spare | rs_dac_a | rs_dac_b | rs_eq;
    wire [15:0] rd_mux = ({16{rs_pad}} & pad_q) | ({16{rs_spare}} & spare_view)
                       | ({16{rs_dac_a}} & dac_a_q) | ({16{rs_dac_b}} & dac_b_q)
                       | ({16{rs_eq}} & eq_q);
    wire rd_fire = arvalid & arready;
    assign arready = ~rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= phy_io_cfg_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_mux};
            rresp_q <= rs_hit ? phy_io_cfg_pkg::RESP_OKAY : phy_io_cfg_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end
    // RULE_01 pad termination
    assign mac_pad_termination_sel = pad_q[phy_io_cfg_pkg::TERM_LSB +: 2];
    // pad input is asynchronous to mclk
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= shared_pin_i;
            pin_sync_q <= pin_meta_q;
        end
    end
    assign led1_gpio_in = pin_sync_q;
    // RULE_02 shared pin ownership
    assign shared_pin_o = clk25_out_disable ? shared_pad_gpio_control[0] : clk25_output;
    assign shared_pin_oe = clk25_out_disable ? shared_pad_gpio_control[1] : 1'b1;
    // RULE_03 pin2 function mux
    // clocks pass the mux unregistered; a flop would kill them
    assign pin2_out = (pin2_function_sel == phy_io_cfg_pkg::P2_CLK50)
                          ? (pin2_src.clk50_output & master_mode)
                    : (pin2_function_sel == phy_io_cfg_pkg::P2_LED2) ? pin2_src.second_led_out
                    : (pin2_function_sel == phy_io_cfg_pkg::P2_WAKE) ? pin2_src.wake_event_out
                    : (pin2_function_sel == phy_io_cfg_pkg::P2_MGMT_INTERRUPT_OUT)
                          ? pin2_src.mgmt_interrupt_out
                    : (pin2_function_sel == phy_io_cfg_pkg::P2_HIGH);

    // RULE_05 rx clock and disabled freeze
    assign rx_ref_clk_sel = spare_q[phy_io_cfg_pkg::RXCLK_SEL_BIT];
    assign loop_freeze.freeze_all = spare_q[phy_io_cfg_pkg::FRZ_RXDIS_BIT]
                                  & lpi_state.receiver_disabled;
    // RULE_06 mse bypass and settled freeze
    assign loop_freeze.mse_bypass = spare_q[phy_io_cfg_pkg::MSE_BYP_BIT]
                                  & lpi_state.low_power_idle_wake_state;
    assign loop_freeze.settled_freeze_en = spare_q[phy_io_cfg_pkg::SETTLE_FRZ_BIT]
                                         & lpi_state.settled_adapt_state;
    // RULE_08 per-loop wait freeze
    assign loop_freeze.wait_freeze = spare_q[phy_io_cfg_pkg::WAIT_FRZ_LSB +: 6]
                                   & {6{lpi_state.low_power_idle_wait_state}};

    // RULE_07 counter-timed refresh freeze
    low_power_idle_freeze_state_timer #(
        .SHORT_CYC(FRZ_SHORT_CYC),
        .LONG_CYC(FRZ_LONG_CYC)
    ) u_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(spare_q[phy_io_cfg_pkg::CNT_FRZ_EN_BIT]),
        .long_sel(spare_q[phy_io_cfg_pkg::CNT_FRZ_LONG_BIT]),
        .refresh(lpi_state.lpi_refresh),
        .freeze(loop_freeze.counter_freeze)
    );

    // RULE_13 ffe stage1 timer
    assign ffe_stage1_timer = eq_q[phy_io_cfg_pkg::FFE1_TMR_LSB +: 3];
    // RULE_14 ffe stage1 hold
    assign ffe_stage1_freeze = eq_q[phy_io_cfg_pkg::FFE1_HOLD_BIT] & ffe_stage1_active;
    assign dsp_aux_cfg = eq_q[6:0];
    // RULE_10 RULE_11 RULE_12 symbol level codes
    wire [5:0] ld_code_d = (mlt3_symbol == phy_io_cfg_pkg::SYM_MINUS)
                               ? dac_a_q[phy_io_cfg_pkg::DAC_M1_LSB +: 6]
                         : (mlt3_symbol == phy_io_cfg_pkg::SYM_PLUS)
                               ? dac_b_q[phy_io_cfg_pkg::DAC_P1_LSB +: 6]
                         : dac_a_q[phy_io_cfg_pkg::DAC_ZERO_LSB +: 6];
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ld_code_q <= 6'h00;
        end else begin
            ld_code_q <= ld_code_d;
        end
    end
    assign ld_code = ld_code_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_term_wr;
        do_wr && ws_pad && wstrb_q[1];
    endsequence
    property p_term;
        s_term_wr |=> mac_pad_termination_sel == $past(wdata_q[15:14]);
    endproperty
    a_term: assert property (p_term) else $error("termination not updated"); // RULE_01
    property p_clk25;
        !clk25_out_disable |-> shared_pin_oe && (shared_pin_o == clk25_output);
    endproperty
    a_clk25: assert property (p_clk25) else $error("25 MHz clock not on pin"); // RULE_02
    property p_pin2_lvl;
        (pin2_function_sel == 3'h6) |-> pin2_out;
    endproperty
    a_pin2_lvl: assert property (p_pin2_lvl) else $error("pin2 not high"); // RULE_03
    property p_pin2_low;
        (pin2_function_sel inside {3'h3, 3'h5, 3'h7}) |-> !pin2_out;
    endproperty
    a_pin2_low: assert property (p_pin2_low) else $error("pin2 not low"); // RULE_03
    sequence s_rd_spare;
        rd_fire && rs_spare;
    endsequence
    property p_rev;
        s_rd_spare |=> rvalid && rdata[1] == REV_ID_BIT && rdata[0] == $past(clk25_out_disable);
    endproperty
    a_rev: assert property (p_rev) else $error("spare low bits wrong"); // RULE_04
    property p_frz_all;
        lpi_state.receiver_disabled && spare_q[4] |-> loop_freeze.freeze_all;
    endproperty
    a_frz_all: assert property (p_frz_all) else $error("loops not frozen"); // RULE_05
    property p_wait;
        lpi_state.low_power_idle_wait_state |-> loop_freeze.wait_freeze == spare_q[15:10];
    endproperty
    a_wait: assert property (p_wait) else $error("wait freeze mismatch"); // RULE_08
    property p_minus;
        mlt3_symbol == phy_io_cfg_pkg::SYM_MINUS |=> ld_code == $past(dac_a_q[11:6]);
    endproperty
    a_minus: assert property (p_minus) else $error("minus code wrong"); // RULE_10
    property p_plus;
        mlt3_symbol == phy_io_cfg_pkg::SYM_PLUS |=> ld_code == $past(dac_b_q[5:0]);
    endproperty
    a_plus: assert property (p_plus) else $error("plus code wrong"); // RULE_12
    property p_ffe1;
        ffe_stage1_active && eq_q[7] |-> ffe_stage1_freeze && ffe_stage1_timer == eq_q[10:8];
    endproperty
    a_ffe1: assert property (p_ffe1) else $error("ffe stage1 not held"); // RULE_14
    property p_resv;
        rd_fire && rs_dac_b |=> rdata[31:6] == 26'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits nonzero"); // RULE_15
    property p_bhold;
        bvalid && !bready |=> bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
endmodule

// ### verif/phy_io_dsp_config_regs_tb.sv
// self-checking bench for the pad, pin, loop freeze and line driver register bank
`timescale 1ns/1ps
module phy_io_dsp_config_regs_tb;
    typedef struct packed {
        logic [13:0] a;
        logic [15:0] wd;
        logic [15:0] rd;
        logic [1:0] rs;
    } row_t;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [13:0] awaddr = 14'h0, araddr = 14'h0;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic clk25_output = 1'b0, shared_pin_i = 1'b0, master_mode = 1'b1, ffe_stage1_active = 1'b0;
    logic [1:0] shared_pad_gpio_control = 2'h0;
    phy_io_cfg_pkg::pin2_src_t pin2_src = '0;
    phy_io_cfg_pkg::lpi_state_t lpi_state = '0;
    phy_io_cfg_pkg::mlt3_t mlt3_symbol = phy_io_cfg_pkg::SYM_ZERO;
    logic awready, wready, bvalid, arready, rvalid, shared_pin_o, shared_pin_oe, led1_gpio_in;
    logic pin2_out, rx_ref_clk_sel, ffe_stage1_freeze;
    logic [1:0] bresp, rresp, mac_pad_termination_sel;
    logic [31:0] rdata;
    logic [2:0] ffe_stage1_timer;
    logic [6:0] dsp_aux_cfg;
    logic [5:0] ld_code;
    phy_io_cfg_pkg::loop_freeze_t loop_freeze;
    int n_mismatch = 0, n_checks = 0, cycles = 0, i, j, cnt;
    logic [31:0] d;
    logic [1:0] r;
    logic [13:0] ra [5] = '{phy_io_cfg_pkg::BA_PAD, phy_io_cfg_pkg::BA_SPARE,
        phy_io_cfg_pkg::BA_DAC_A, phy_io_cfg_pkg::BA_DAC_B, phy_io_cfg_pkg::BA_EQ};
    logic [15:0] re [5] = '{16'h0000, 16'h0000, 16'h0c00, 16'h0020, 16'h0464};
    // write then read back; spare bit 0 follows the clock-off bit of the pad register
    row_t rows [7] = '{
        '{phy_io_cfg_pkg::BA_PAD, 16'hffff, 16'hc047, 2'h0},
        '{phy_io_cfg_pkg::BA_SPARE, 16'hffff, 16'hfffd, 2'h0},
        '{phy_io_cfg_pkg::BA_DAC_A, 16'hffff, 16'h0fff, 2'h0},
        '{phy_io_cfg_pkg::BA_DAC_B, 16'hffff, 16'h003f, 2'h0},
        '{phy_io_cfg_pkg::BA_EQ, 16'hffff, 16'h07ff, 2'h0},
        '{14'h0000, 16'h1234, 16'h0000, 2'h2},
        '{phy_io_cfg_pkg::BA_PAD, 16'h0000, 16'h0000, 2'h0}};

    phy_io_dsp_config_regs #(.FRZ_SHORT_CYC(20), .FRZ_LONG_CYC(30)) i_dut (
        .mclk, .rst_n, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid,
        .rready, .rdata, .rresp, .mac_pad_termination_sel, .clk25_output,
        .shared_pad_gpio_control, .shared_pin_i, .shared_pin_o, .shared_pin_oe, .led1_gpio_in,
        .master_mode, .pin2_src, .pin2_out, .lpi_state, .ffe_stage1_active, .loop_freeze,
        .rx_ref_clk_sel, .ffe_stage1_timer, .ffe_stage1_freeze, .dsp_aux_cfg, .mlt3_symbol,
        .ld_code);

    always #10 mclk = ~mclk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // run is about 350 cycles; a hang runs into this ceiling
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic chk_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_pin(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // address and data offered together, each released once taken
    task automatic wr(input logic [13:0] a, input logic [15:0] v, output logic [1:0] rs);
        bit ad, dd;
        ad = 0;
        dd = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= {16'h0, v};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge mclk);
            if (awvalid && awready) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                dd = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [13:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge mclk); while (!rvalid);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    function automatic logic f_pin2(input logic [2:0] s, input logic [3:0] src, input logic mm);
        case (s)
            3'h0: return src[3] & mm;
            3'h1: return src[2];
            3'h2: return src[1];
            3'h4: return src[0];
            3'h6: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        for (i = 0; i < 5; i++) begin
            rd(ra[i], d, r);
            chk_bus("reset value", {16'h0, re[i]}, d);
        end
        $display("done: reset values");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].wd, r);
            chk_bus("bresp", rows[i].rs, r);
            rd(rows[i].a, d, r);
            chk_bus("rresp", rows[i].rs, r);
            chk_bus("read back", {16'h0, rows[i].rd}, d);
        end
        $display("done: register rows");
        for (j = 0; j < 3; j++) begin
            pin2_src <= (j == 0) ? 4'h5 : 4'ha;
            master_mode <= (j != 2);
            for (i = 0; i < 8; i++) begin
                wr(phy_io_cfg_pkg::BA_PAD, 16'h4000 | 16'(i), r);
                #1;
                chk_pin("pin2", 16'(f_pin2(3'(i), (j == 0) ? 4'h5 : 4'ha, j != 2)), 16'(pin2_out));
                chk_pin("termination", 16'h1, 16'(mac_pad_termination_sel));
            end
        end
        $display("done: pin functions");
        clk25_output <= 1'b1;
        shared_pad_gpio_control <= 2'h2;
        shared_pin_i <= 1'b1;
        @(posedge mclk);
        #1;
        chk_pin("clk25 pin", 16'h3, {shared_pin_oe, shared_pin_o});
        wr(phy_io_cfg_pkg::BA_PAD, 16'h0040, r);
        #1;
        chk_pin("gpio pin", 16'h2, {shared_pin_oe, shared_pin_o});
        chk_pin("led1 input", 16'h1, 16'(led1_gpio_in));
        rd(phy_io_cfg_pkg::BA_SPARE, d, r);
        chk_bus("clock-off flag", 32'h1, d & 32'h3);
        $display("done: shared pin");
        wr(phy_io_cfg_pkg::BA_DAC_A, 16'h054a, r);
        wr(phy_io_cfg_pkg::BA_DAC_B, 16'h0033, r);
        mlt3_symbol <= phy_io_cfg_pkg::SYM_PLUS;
        @(posedge mclk);
        mlt3_symbol <= phy_io_cfg_pkg::SYM_MINUS;
        #1;
        chk_pin("plus code", 16'h33, 16'(ld_code));
        @(posedge mclk);
        mlt3_symbol <= phy_io_cfg_pkg::SYM_ZERO;
        #1;
        chk_pin("minus code", 16'h15, 16'(ld_code));
        @(posedge mclk);
        #1;
        chk_pin("zero code", 16'h0a, 16'(ld_code));
        $display("done: line driver");
        wr(phy_io_cfg_pkg::BA_SPARE, 16'hfc74, r);
        lpi_state <= 6'h36;
        @(posedge mclk);
        #1;
        chk_pin("freeze set", 16'h13f | 16'h200 | 16'h100 | 16'h80, 16'(loop_freeze));
        chk_pin("rx clk select", 16'h1, 16'(rx_ref_clk_sel));
        lpi_state <= 6'h0;
        @(posedge mclk);
        #1;
        chk_pin("freeze clear", 16'h0, 16'(loop_freeze));
        for (j = 0; j < 2; j++) begin
            wr(phy_io_cfg_pkg::BA_SPARE, (j == 0) ? 16'h0080 : 16'h0180, r);
            lpi_state <= 6'h01;
            cnt = 0;
            @(posedge mclk);
            lpi_state <= 6'h00;
            repeat (60) begin
                @(posedge mclk);
                cnt += loop_freeze.counter_freeze;
            end
            chk_pin("timed freeze", (j == 0) ? 16'd20 : 16'd30, 16'(cnt));
        end
        $display("done: loop freezes");
        wr(phy_io_cfg_pkg::BA_EQ, 16'h03a5, r);
        ffe_stage1_active <= 1'b1;
        @(posedge mclk);
        #1;
        chk_pin("ffe timer", 16'h3, 16'(ffe_stage1_timer));
        chk_pin("ffe hold", 16'h1, 16'(ffe_stage1_freeze));
        chk_pin("aux cfg", 16'h25, 16'(dsp_aux_cfg));
        ffe_stage1_active <= 1'b0;
        @(posedge mclk);
        #1;
        chk_pin("ffe run", 16'h0, 16'(ffe_stage1_freeze));
        wr(phy_io_cfg_pkg::BA_EQ, 16'h0325, r);
        ffe_stage1_active <= 1'b1;
        @(posedge mclk);
        #1;
        chk_pin("ffe no hold", 16'h0, 16'(ffe_stage1_freeze));
        $display("done: equalizer");
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        for (i = 0; i < 5; i++) begin
            rd(ra[i], d, r);
            chk_bus("reset again", {16'h0, re[i]}, d);
        end
        $display("done: second reset");
        close_out();
    end
endmodule
